// ==== image_pixel_port.sv ====
// image sensor pixel output port: frame timing, snapshot and pin control
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - free-running full frames at 12 fps from reset
// - one 10-bit pixel word, bit 9 MSB
// - output enable high puts outputs in high impedance
// - reset low returns everything to defaults asynchronously
// - outputs stable at falling pixel clock edge
// - pixel clock equals master clock frequency
// - image_active high exactly over valid frame
// - row_active over valid line, mode selectable
// - flash strobe pulses after array reset completes
// - trigger falling edge requests a single-frame snapshot
// - standby high disables analog bias
// - rows read out progressively, first to last
// - horizontal and vertical blanking carry no data
// - blanking counted in clocks and row times
// - snapshot starts at trigger fall or software
module image_pixel_port
  import pixel_port_pkg::*;
#(
  parameter int COLS = FULL_COLS,
  parameter int ROWS = FULL_ROWS,
  parameter int HBLANK = HBLANK_PIX,
  parameter int VBLANK = VBLANK_ROWS,
  parameter int RESET_SEQ_CYCLES = FULL_ROWS * ROW_RESET_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic master_clock_in,
  input wire logic output_enable_n,
  input wire logic standby,
  input wire logic snapshot_trigger,
  input wire logic snapshot_mode,
  input wire logic soft_snapshot,
  input wire logic row_valid_mode,
  input wire logic [PIX_W-1:0] pix_in_data,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  output logic [PIX_W-1:0] pixel_word,
  output logic image_active,
  output logic row_active,
  output logic pix_sample_clock,
  output logic flash_strobe,
  output logic outputs_oe_n,
  output logic analog_bias_en,
  output logic snapshot_busy
);

  localparam int LINE = COLS + HBLANK;
  localparam int COL_W = $clog2(LINE + 1);
  localparam int ROW_W = $clog2(((ROWS > VBLANK) ? ROWS : VBLANK) + 1);

  // ----------------------------------------------------------------
  // state of both clock domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic oe1;
    logic oe2;
    logic sb1;
    logic sb2;
    logic md1;
    logic md2;
    logic tg1;
    logic tg2;
    logic tg3;
    logic pend;
    line_state_t st;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [PIX_W-1:0] word;
    logic img;
    logic lv;
  } link_t;

  typedef struct packed {
    logic trg1;
    logic trg2;
    logic trg3;
    logic sb1;
    logic sb2;
    snap_state_t st;
    logic [SEQ_W-1:0] cnt;
    logic tog;
    logic strobe;
    logic bias;
  } ref_t;

  link_t l_r;
  link_t l_nxt;
  ref_t f_r;
  ref_t f_nxt;

  logic buf_valid;
  logic buf_ready;
  logic [PIX_W-1:0] buf_dout;
  logic take;
  logic snap_edge;
  logic start;
  logic trig_fall;
  logic snap_req;

  function automatic logic [COL_W-1:0] col_inc(input logic [COL_W-1:0] c);
    return COL_W'(c + 1'h1);
  endfunction
  function automatic logic [ROW_W-1:0] row_inc(input logic [ROW_W-1:0] r);
    return ROW_W'(r + 1'h1);
  endfunction

  // ----------------------------------------------------------------
  // pixel source buffer on the link clock
  // ----------------------------------------------------------------
  pix_buf #(
    .WIDTH(PIX_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(master_clock_in),
    .reset_n(reset_n),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .in_data(pix_in_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_dout)
  );

  assign buf_ready = (l_r.st == LS_ACTIVE);
  assign take = buf_valid && buf_ready;

  // ----------------------------------------------------------------
  // link domain: frame and line timing
  // ----------------------------------------------------------------
  assign snap_edge = l_r.tg2 ^ l_r.tg3;
  // a frame waits for a snapshot only in snapshot mode
  assign start = l_r.rs2 && !l_r.sb2 && (l_r.st == LS_IDLE) && (!l_r.md2 || l_r.pend);

  always_comb begin
    l_nxt = l_r;
    l_nxt.rs1 = 1'h1;
    l_nxt.rs2 = l_r.rs1;
    l_nxt.oe1 = output_enable_n;
    l_nxt.oe2 = l_r.oe1;
    l_nxt.sb1 = standby;
    l_nxt.sb2 = l_r.sb1;
    l_nxt.md1 = snapshot_mode;
    l_nxt.md2 = l_r.md1;
    l_nxt.tg1 = f_r.tog;
    l_nxt.tg2 = l_r.tg1;
    l_nxt.tg3 = l_r.tg2;
    // a new request in the consuming cycle survives
    l_nxt.pend = snap_edge || (l_r.pend && !(start && l_r.md2));
    unique case (l_r.st)
      LS_IDLE: begin
        l_nxt.lv = 1'h0;
        l_nxt.img = 1'h0;
        if (start) begin
          l_nxt.st = LS_ACTIVE;
          l_nxt.img = 1'h1;
          l_nxt.col = '0;
          l_nxt.row = '0;
        end
      end
      LS_ACTIVE: begin
        if (take) begin
          l_nxt.word = buf_dout;
          l_nxt.lv = 1'h1;
          if (l_r.col == COL_W'(COLS - 1)) begin
            l_nxt.col = '0;
            if (l_r.row == ROW_W'(ROWS - 1)) begin
              l_nxt.st = LS_VBLANK;
              l_nxt.row = '0;
            end else begin
              l_nxt.st = LS_HBLANK;
            end
          end else begin
            l_nxt.col = col_inc(l_r.col);
          end
        end else begin
          // starved source: hold mode keeps the line high across the gap
          l_nxt.lv = (row_valid_mode == LV_HOLD) && (l_r.col != '0);
        end
      end
      LS_HBLANK: begin
        l_nxt.lv = 1'h0;
        if (l_r.col == COL_W'(HBLANK - 1)) begin
          l_nxt.col = '0;
          l_nxt.row = row_inc(l_r.row);
          l_nxt.st = LS_ACTIVE;
        end else begin
          l_nxt.col = col_inc(l_r.col);
        end
      end
      LS_VBLANK: begin
        l_nxt.lv = 1'h0;
        l_nxt.img = 1'h0;
        if (l_r.col == COL_W'(LINE - 1)) begin
          l_nxt.col = '0;
          if (l_r.row == ROW_W'(VBLANK - 1)) begin
            l_nxt.row = '0;
            l_nxt.st = LS_IDLE;
          end else begin
            l_nxt.row = row_inc(l_r.row);
          end
        end else begin
          l_nxt.col = col_inc(l_r.col);
        end
      end
      default: begin
        l_nxt.st = LS_IDLE;
        l_nxt.lv = 1'h0;
        l_nxt.img = 1'h0;
      end
    endcase
  end

  // outputs update on the rising edge, so they hold over the falling one
  always_ff @(posedge master_clock_in or negedge reset_n) begin
    if (!reset_n) begin
      l_r <= '{oe1: 1'h1, oe2: 1'h1, st: LS_IDLE, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------------------------------
  // ref domain: trigger, array reset sequence and strobe
  // ----------------------------------------------------------------
  assign trig_fall = f_r.trg3 && !f_r.trg2;
  assign snap_req = snapshot_mode && !f_r.sb2 && (trig_fall || soft_snapshot);

  always_comb begin
    f_nxt = f_r;
    f_nxt.trg1 = snapshot_trigger;
    f_nxt.trg2 = f_r.trg1;
    f_nxt.trg3 = f_r.trg2;
    f_nxt.sb1 = standby;
    f_nxt.sb2 = f_r.sb1;
    f_nxt.bias = !f_r.sb2;
    unique case (f_r.st)
      SN_IDLE: begin
        // requests during a running sequence are dropped
        if (snap_req) begin
          f_nxt.st = SN_RESET;
          f_nxt.cnt = '0;
        end
      end
      SN_RESET: begin
        if (f_r.cnt == SEQ_W'(RESET_SEQ_CYCLES - 1)) begin
          f_nxt.st = SN_STROBE;
          f_nxt.cnt = '0;
          f_nxt.strobe = 1'h1;
          f_nxt.tog = !f_r.tog;
        end else begin
          f_nxt.cnt = SEQ_W'(f_r.cnt + 1'h1);
        end
      end
      SN_STROBE: begin
        if (f_r.cnt == SEQ_W'(STROBE_CYC - 1)) begin
          f_nxt.st = SN_IDLE;
          f_nxt.cnt = '0;
          f_nxt.strobe = 1'h0;
        end else begin
          f_nxt.cnt = SEQ_W'(f_r.cnt + 1'h1);
        end
      end
      default: begin
        f_nxt.st = SN_IDLE;
        f_nxt.strobe = 1'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      f_r <= '{st: SN_IDLE, bias: 1'h1, default: '0};
    end else begin
      f_r <= f_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // master clock passed straight through; host keeps it within 48 MHz
  assign pix_sample_clock = master_clock_in;
  assign pixel_word = l_r.word;
  assign image_active = l_r.img;
  assign row_active = l_r.lv;
  assign outputs_oe_n = l_r.oe2;
  assign flash_strobe = f_r.strobe;
  assign analog_bias_en = f_r.bias;
  assign snapshot_busy = (f_r.st != SN_IDLE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  oe_hiz_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    output_enable_n [*3] |-> outputs_oe_n)
    else $error("outputs not released after enable went high");
  oe_drive_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    !output_enable_n [*3] |-> !outputs_oe_n)
    else $error("outputs not driven while enabled");
  line_in_frame_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    row_active |-> image_active)
    else $error("row active outside a frame");
  frame_gap_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_VBLANK && $past(l_r.st) == LS_VBLANK) |-> !image_active)
    else $error("frame active during vertical blanking");
  hblank_quiet_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_HBLANK) |-> (image_active && ($past(l_r.st) != LS_HBLANK || !row_active)))
    else $error("bad qualifiers in horizontal blanking");
  pixel_take_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    take |=> (row_active && pixel_word == $past(buf_dout)))
    else $error("pixel word not presented after take");
  row_order_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_ACTIVE && $past(l_r.st) == LS_HBLANK) |->
      (l_r.row == ROW_W'($past(l_r.row) + 1'h1)))
    else $error("rows not in progressive order");
  vblank_len_a: assert property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_IDLE && $past(l_r.st) == LS_VBLANK) |->
      ($past(l_r.row) == ROW_W'(VBLANK - 1) && $past(l_r.col) == COL_W'(LINE - 1)))
    else $error("vertical blanking length wrong");
  strobe_width_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(flash_strobe) |-> flash_strobe [*5] ##1 !flash_strobe)
    else $error("strobe width wrong");
  strobe_cause_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(flash_strobe) |->
      ($past(f_r.st) == SN_RESET && $past(f_r.cnt) == SEQ_W'(RESET_SEQ_CYCLES - 1)))
    else $error("strobe without completed array reset");
  trig_fall_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (trig_fall && snapshot_mode && !f_r.sb2 && f_r.st == SN_IDLE) |=> snapshot_busy)
    else $error("trigger fall did not start snapshot");
  bias_off_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    standby [*4] |-> !analog_bias_en)
    else $error("bias still enabled in standby");
  frame_done_c: cover property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_VBLANK) ##1 (l_r.st == LS_IDLE));
  starved_gap_c: cover property (
    @(posedge master_clock_in) disable iff (!reset_n)
    (l_r.st == LS_ACTIVE && !buf_valid && l_r.col != '0));
  strobe_c: cover property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(flash_strobe));
  hiz_c: cover property (
    @(posedge master_clock_in) disable iff (!reset_n)
    $rose(outputs_oe_n));
endmodule
`default_nettype wire

// ==== pixel_port_pkg.sv ====
// shared constants and state encodings for the pixel output port
package pixel_port_pkg;

  // ----------------------------------------------------------------
  // pixel format and default frame geometry
  // ----------------------------------------------------------------
  localparam int PIX_W = 10;
  localparam int FULL_COLS = 2048;
  localparam int FULL_ROWS = 1536;
  localparam int FRAME_RATE_FPS = 12;
  localparam int MASTER_CLK_HZ = 48000000;
  // 2498 clocks x 1601 row times at 48 MHz gives 12 frames per second
  localparam int HBLANK_PIX = 450;
  localparam int VBLANK_ROWS = 65;

  // ----------------------------------------------------------------
  // snapshot timing on ref_clk
  // ----------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 10;
  localparam int ROW_RESET_NS = 100;
  localparam int STROBE_NS = 50;

  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ROW_RESET_CYC = ceil_cycles(ROW_RESET_NS);
  localparam int STROBE_CYC = ceil_cycles(STROBE_NS);
  localparam int SEQ_W = 24;

  // ----------------------------------------------------------------
  // row qualifier modes and state encodings
  // ----------------------------------------------------------------
  localparam logic LV_STRICT = 1'h0;
  localparam logic LV_HOLD = 1'h1;

  typedef enum logic [3:0] {
    LS_IDLE = 4'h1,
    LS_ACTIVE = 4'h2,
    LS_HBLANK = 4'h4,
    LS_VBLANK = 4'h8
  } line_state_t;

  typedef enum logic [2:0] {
    SN_IDLE = 3'h1,
    SN_RESET = 3'h2,
    SN_STROBE = 3'h4
  } snap_state_t;

endpackage

// ==== pix_buf.sv ====
// small valid/ready buffer built from flip-flops
`timescale 1ns/1ns
`default_nettype none
module pix_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
  } buf_t;

  buf_t s_r;
  buf_t s_nxt;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'h1);
  endfunction

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign in_ready = (s_r.cnt != CNT_W'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = ptr_inc(s_r.wp);
    end
    if (pop) begin
      s_nxt.rp = ptr_inc(s_r.rp);
    end
    if (push && !pop) begin
      s_nxt.cnt = CNT_W'(s_r.cnt + 1'h1);
    end else if (pop && !push) begin
      s_nxt.cnt = CNT_W'(s_r.cnt - 1'h1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  buf_fill_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.cnt <= CNT_W'(DEPTH)))
    else $error("buffer count beyond depth");

endmodule
`default_nettype wire

// ==== host_capture.sv ====
// host capture model: samples the pixel link on the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module host_capture
  import pixel_port_pkg::*;
#(
  parameter int HBLANK = 3
) (
  input wire logic pix_sample_clock,
  input wire logic reset_n,
  input wire logic outputs_oe_n,
  input wire logic [PIX_W-1:0] pixel_word,
  input wire logic image_active,
  input wire logic row_active,
  output int frames,
  output int last_rows,
  output int last_words,
  output int seq_err,
  output int gap_err
);
  // ----------------------------------------
  // falling edge capture
  // ----------------------------------------
  logic [PIX_W-1:0] prev_w;
  logic have_prev;
  logic img_q;
  logic row_q;
  int rows;
  int words;
  int gap;
  always @(negedge pix_sample_clock or negedge reset_n) begin
    if (!reset_n) begin
      {have_prev, img_q, row_q} <= 3'h0;
      prev_w <= 10'h000;
      {frames, rows, words, gap, seq_err, gap_err, last_rows, last_words} <= '0;
    end else if (outputs_oe_n === 1'b0) begin
      img_q <= image_active;
      row_q <= row_active;
      if (row_active && !image_active) seq_err <= seq_err + 1;
      if (image_active && !img_q) begin
        rows <= 0;
        words <= 0;
      end else if (row_active) begin
        words <= words + 1;
        if (!row_q) rows <= rows + 1;
        // first row of each frame has no measured gap
        if (!row_q && rows > 0 && gap != HBLANK) gap_err <= gap_err + 1;
        gap <= 0;
        if (have_prev && pixel_word !== prev_w + 1'b1) seq_err <= seq_err + 1;
        prev_w <= pixel_word;
        have_prev <= 1'b1;
      end else if (image_active) begin
        gap <= gap + 1;
      end
      if (!image_active && img_q) begin
        frames <= frames + 1;
        last_rows <= rows;
        last_words <= words;
      end
    end
  end
endmodule
`default_nettype wire

// ==== image_pixel_port_tb.sv ====
// testbench for the image pixel output port
`timescale 1ns/1ns
`default_nettype none
module image_pixel_port_tb
  import pixel_port_pkg::*;
;
  localparam int NC = 8;
  localparam int NR = 4;
  localparam int HB = 3;
  localparam int RSC = 20;
  logic ref_clk, reset_n, master_clock_in, output_enable_n, standby;
  logic snapshot_trigger, snapshot_mode, soft_snapshot, row_valid_mode;
  logic pix_in_valid, pix_in_ready, image_active, row_active, pix_sample_clock;
  logic flash_strobe, outputs_oe_n, analog_bias_en, snapshot_busy, src_stall;
  logic [PIX_W-1:0] pix_in_data;
  logic [PIX_W-1:0] pixel_word;
  int frames, last_rows, last_words, seq_err, gap_err;
  int miscompares;
  int cmp_count;
  // ----------------------------------------
  // clocks, source and instances
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // even offset keeps link edges off the ref sampling edges
  initial begin
    master_clock_in = 1'b0;
    #2;
    forever #32 master_clock_in = ~master_clock_in;
  end
  always @(posedge master_clock_in) begin
    if (!reset_n) begin
      pix_in_valid <= 1'b0;
    end else if (pix_in_valid && pix_in_ready) begin
      pix_in_data <= pix_in_data + 1'b1;
      pix_in_valid <= !(src_stall && pix_in_data[1:0] == 2'h3);
    end else if (!pix_in_valid) begin
      pix_in_valid <= 1'b1;
    end
  end
  image_pixel_port #(.COLS(NC), .ROWS(NR), .HBLANK(HB), .VBLANK(2),
    .RESET_SEQ_CYCLES(RSC), .BUF_DEPTH(2)) image_pixel_port_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .master_clock_in(master_clock_in),
    .output_enable_n(output_enable_n), .standby(standby),
    .snapshot_trigger(snapshot_trigger), .snapshot_mode(snapshot_mode),
    .soft_snapshot(soft_snapshot), .row_valid_mode(row_valid_mode),
    .pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
    .pixel_word(pixel_word), .image_active(image_active), .row_active(row_active),
    .pix_sample_clock(pix_sample_clock), .flash_strobe(flash_strobe),
    .outputs_oe_n(outputs_oe_n), .analog_bias_en(analog_bias_en),
    .snapshot_busy(snapshot_busy));
  host_capture #(.HBLANK(HB)) host_capture_i (
    .pix_sample_clock(pix_sample_clock), .reset_n(reset_n), .outputs_oe_n(outputs_oe_n),
    .pixel_word(pixel_word), .image_active(image_active), .row_active(row_active),
    .frames(frames), .last_rows(last_rows), .last_words(last_words),
    .seq_err(seq_err), .gap_err(gap_err));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // sample after the edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_frames(input int n);
    int target;
    int i;
    target = frames + n;
    for (i = 0; i < 3000 * n && frames < target; i++) tick(1);
    if (frames < target) begin
      miscompares++;
      $display("ERROR frames expected %0d seen %0d", target, frames);
      wrap_up();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check_reset();
    chk("outputs_oe_n", 1, outputs_oe_n);
    chk("pixel_word", 0, pixel_word);
    chk("image_active", 0, image_active);
    chk("row_active", 0, row_active);
    chk("flash_strobe", 0, flash_strobe);
    chk("analog_bias_en", 1, analog_bias_en);
    chk("snapshot_busy", 0, snapshot_busy);
    chk("pix_in_ready", 1, pix_in_ready);
  endtask
  task automatic check_oe();
    repeat (4) @(posedge master_clock_in);
    tick(1);
    chk("outputs_oe_n", 1, outputs_oe_n);
    @(posedge ref_clk) output_enable_n <= 1'b0;
    repeat (4) @(posedge master_clock_in);
    tick(1);
    chk("outputs_oe_n", 0, outputs_oe_n);
    repeat (3) begin
      tick(3);
      chk("pix_sample_clock", master_clock_in, pix_sample_clock);
    end
  endtask
  task automatic free_run();
    wait_frames(2);
    chk("rows", NR, last_rows);
    chk("words", NC * NR, last_words);
    chk("seq_err", 0, seq_err);
    chk("gap_err", 0, gap_err);
    tick(10);
    chk("pix_in_ready", 0, pix_in_ready);
  endtask
  task automatic strict_stall();
    @(posedge master_clock_in) src_stall <= 1'b1;
    wait_frames(2);
    chk("words", NC * NR, last_words);
    chk("rows split", 1, last_rows > NR);
    chk("seq_err", 0, seq_err);
    @(posedge master_clock_in) src_stall <= 1'b0;
  endtask
  // hold mode: starved cycles keep the line up, so no row is split
  task automatic hold_stall();
    @(posedge master_clock_in) begin
      src_stall <= 1'b1;
      row_valid_mode <= 1'b1;
    end
    wait_frames(2);
    chk("rows hold", NR, last_rows);
    chk("words hold", 1, last_words > NC * NR);
    @(posedge master_clock_in) begin
      src_stall <= 1'b0;
      row_valid_mode <= 1'b0;
    end
  endtask
  task automatic snapshot();
    int f0;
    int i;
    int n;
    @(posedge ref_clk) snapshot_mode <= 1'b1;
    tick(1000);
    f0 = frames;
    tick(1000);
    chk("frames idle", f0, frames);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        @(posedge ref_clk) snapshot_trigger <= 1'b1;
        tick(10);
        chk("busy on high", 0, snapshot_busy);
        @(posedge ref_clk) snapshot_trigger <= 1'b0;
      end else begin
        @(posedge ref_clk) soft_snapshot <= 1'b1;
        @(posedge ref_clk) soft_snapshot <= 1'b0;
        // busy launches on this edge; look only once it has settled
        #1;
      end
      for (i = 0; i < 10 && snapshot_busy !== 1'b1; i++) tick(1);
      chk("snapshot_busy", 1, snapshot_busy);
      for (n = 0; n < RSC + 10 && flash_strobe !== 1'b1; n++) tick(1);
      chk("strobe delay", RSC, n);
      for (n = 0; n < 20 && flash_strobe === 1'b1; n++) tick(1);
      chk("strobe width", STROBE_CYC, n);
      chk("busy after", 0, snapshot_busy);
      tick(1500);
      chk("frames", f0 + k + 1, frames);
    end
  endtask
  task automatic standby_test();
    @(posedge ref_clk) standby <= 1'b1;
    tick(5);
    chk("analog_bias_en", 0, analog_bias_en);
    @(posedge ref_clk) soft_snapshot <= 1'b1;
    @(posedge ref_clk) soft_snapshot <= 1'b0;
    tick(5);
    chk("busy standby", 0, snapshot_busy);
    @(posedge ref_clk) standby <= 1'b0;
    tick(5);
    chk("analog_bias_en", 1, analog_bias_en);
  endtask
  // reset in mid-frame, held over two link edges, then free run again
  task automatic mid_reset();
    @(posedge ref_clk) snapshot_mode <= 1'b0;
    tick(300);
    @(posedge ref_clk) reset_n <= 1'b0;
    repeat (2) @(posedge master_clock_in);
    #1;
    check_reset();
    @(posedge ref_clk) reset_n <= 1'b1;
    wait_frames(1);
    chk("rows", NR, last_rows);
    chk("words", NC * NR, last_words);
    chk("seq_err", 0, seq_err);
  endtask
  initial begin
    {output_enable_n, reset_n, standby, snapshot_trigger} = 4'h8;
    {snapshot_mode, soft_snapshot, row_valid_mode, pix_in_valid, src_stall} = 5'h00;
    pix_in_data = 10'h000;
    miscompares = 0;
    cmp_count = 0;
    repeat (3) @(posedge master_clock_in);
    check_reset();
    @(posedge ref_clk) reset_n <= 1'b1;
    check_oe();
    free_run();
    strict_stall();
    hold_stall();
    snapshot();
    standby_test();
    mid_reset();
    wrap_up();
  end
  initial begin
    #600000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
